/* smbus_seq_pkg.sv */
// Package of constants and types for the SMBus acknowledge and mode sequencer.
package smbus_seq_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_CFG = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_DATA = 3'h2;
  localparam logic [2:0] ADDR_SLV = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  localparam logic [2:0] ADDR_ACK = 3'h5;
  // Configuration register fields.
  localparam int CFG_EN = 0;
  localparam int CFG_INH = 1;
  localparam int CFG_HWACK = 2;
  // Control and status register fields.
  localparam int CTL_SI = 0;
  localparam int CTL_ACK = 1;
  localparam int CTL_ACK_REQUEST_FLAG = 2;
  localparam int CTL_STA = 3;
  localparam int CTL_STO = 4;
  localparam int CTL_TXM = 5;
  localparam int CTL_MST = 6;
  localparam int CTL_ARBL = 7;
  // Bit timing of the generated serial clock.
  localparam int CLK_NS = 5;
  localparam int HALF_NS = 2500;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic PIN_RESET = 1'b1;
  typedef enum logic [2:0] {
    idle = 3'h0,
    gen_start = 3'h1,
    shifting = 3'h3,
    ack_slot = 3'h2,
    hold = 3'h6,
    gen_stop = 3'h7
  } state_t;
endpackage

/* smbus_ack_and_mode_sequencer.sv */
// SMBus byte engine with acknowledge handling and mode sequencing.
// Contract
// - Ack bit: written receiving, sampled when sending.
// - Software-ack mode flags ack request per received byte.
// - Clearing byte event without ack write: nack.
// - Ack write drives SDA; SCL low until clear.
// - Refused address ignores slave events until START.
// - Master from generated START until STOP or loss.
// - Every byte frame raises a byte event; an address refused by hardware ack, or sent while slave inhibit is set, raises none.
// - Receive event before ack unless hardware ack.
// - Master write sends address, direction 0, data.
// - Master transfer ends by stop request and STOP.
// - No data write after master send: receiver.
// - Master read sends direction 1, clocks slave data.
// - Hardware ack answers first, then posts event.
// - Ack bit one acknowledges, zero refuses.
// - Data write as master receiver: transmitter.
// - Uninhibited slave enters receiver on START address.
// - Hardware ack accepts masked own-address matches.
// - STOP ends slave receive; data write: transmitter.
// - Byte event set stalls the bus low; not after a slave-send nack or an arbitration loss.
// - Mask one compares address bit, zero ignores.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module smbus_ack_and_mode_sequencer #(
  parameter int HALF_CYC = smbus_seq_pkg::HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_byte_event,
  output logic o_ack_request
);
  localparam int TW = $clog2(HALF_CYC + 1);
  localparam logic [TW-1:0] HALF_M1 = TW'(HALF_CYC - 1);

  typedef struct packed {
    smbus_seq_pkg::state_t st;
    logic [3:0] cnt;
    logic [7:0] dat;
    logic [TW-1:0] tmr;
    logic [6:0] own;
    logic [6:0] msk;
    logic [7:0] rdata;
    logic en;
    logic slave_inhibit;
    logic hwack;
    logic si;
    logic ack;
    logic ackw;
    logic ack_request_flag;
    logic sta;
    logic stop_request;
    logic txm;
    logic mst;
    logic arbl;
    logic addr_ph;
    logic rw;
    logic dw;
    logic sda_lo;
    logic scl_lo;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic rise, fall, start_det, stop_det, tick, si_clr, match;
  logic [6:0] bit_ok;

  // Both pins pass two flops; edge logic reads only the second and later.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1 <= smbus_seq_pkg::PIN_RESET;
      scl_s2 <= smbus_seq_pkg::PIN_RESET;
      scl_d <= smbus_seq_pkg::PIN_RESET;
      sda_s1 <= smbus_seq_pkg::PIN_RESET;
      sda_s2 <= smbus_seq_pkg::PIN_RESET;
      sda_d <= smbus_seq_pkg::PIN_RESET;
    end else if (i_ce) begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign rise = scl_s2 & ~scl_d;
  assign fall = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign tick = (r.tmr == HALF_M1);

  for (genvar g = 0; g < 7; g++) begin : g_mask
    assign bit_ok[g] = ~r.msk[g] | (r.dat[g+1] == r.own[g]);
  end
  assign match = &bit_ok;

  always_comb begin
    logic ackv;
    logic txm_n;
    ackv = 1'b0;
    txm_n = 1'b0;
    next_r = r;
    next_r.rdata = smbus_seq_pkg::RESET_BYTE;
    si_clr = 1'b0;
    if (i_wr) begin
      case (i_addr)
        smbus_seq_pkg::ADDR_CFG: begin
          next_r.en = i_wdata[smbus_seq_pkg::CFG_EN];
          next_r.slave_inhibit = i_wdata[smbus_seq_pkg::CFG_INH];
          next_r.hwack = i_wdata[smbus_seq_pkg::CFG_HWACK];
        end
        smbus_seq_pkg::ADDR_CTRL: begin
          next_r.sta = i_wdata[smbus_seq_pkg::CTL_STA];
          next_r.stop_request = i_wdata[smbus_seq_pkg::CTL_STO];
          si_clr = r.si & ~i_wdata[smbus_seq_pkg::CTL_SI];
        end
        smbus_seq_pkg::ADDR_DATA: begin
          next_r.dat = i_wdata;
          next_r.dw = 1'b1;
        end
        smbus_seq_pkg::ADDR_SLV: next_r.own = i_wdata[7:1];
        smbus_seq_pkg::ADDR_MASK: next_r.msk = i_wdata[7:1];
        smbus_seq_pkg::ADDR_ACK: begin
          next_r.ack = i_wdata[0];
          next_r.ackw = 1'b1;
          if (r.st == smbus_seq_pkg::hold && r.ack_request_flag) begin
            next_r.sda_lo = i_wdata[0];
          end
        end
        default: begin
        end
      endcase
    end
    if (si_clr) begin
      next_r.si = 1'b0;
      next_r.arbl = 1'b0;
    end
    if (i_rd) begin
      case (i_addr)
        smbus_seq_pkg::ADDR_CFG: next_r.rdata = {5'h00, r.hwack, r.slave_inhibit, r.en};
        smbus_seq_pkg::ADDR_CTRL: next_r.rdata = {r.arbl, r.mst, r.txm,
          r.stop_request, r.sta, r.ack_request_flag, r.ack, r.si};
        smbus_seq_pkg::ADDR_DATA: next_r.rdata = r.dat;
        smbus_seq_pkg::ADDR_SLV: next_r.rdata = {r.own, 1'b0};
        smbus_seq_pkg::ADDR_MASK: next_r.rdata = {r.msk, 1'b0};
        smbus_seq_pkg::ADDR_ACK: next_r.rdata = {7'h00, r.ack};
        default: next_r.rdata = smbus_seq_pkg::RESET_BYTE;
      endcase
    end
    // Master clock: a released SCL counts only while the bus reads high,
    // so a slave that stretches the clock simply delays the next edge.
    if (r.mst && (r.st == smbus_seq_pkg::shifting ||
        r.st == smbus_seq_pkg::ack_slot || r.st == smbus_seq_pkg::gen_stop)) begin
      if (r.scl_lo || scl_s2) begin
        next_r.tmr = r.tmr + 1'b1;
      end
      if (tick) begin
        next_r.tmr = '0;
        next_r.scl_lo = ~r.scl_lo;
      end
    end
    unique case (r.st)
      smbus_seq_pkg::idle: begin
        if (r.en && r.sta && !r.mst && scl_s2 && sda_s2) begin
          next_r.st = smbus_seq_pkg::gen_start;
          next_r.sda_lo = 1'b1;
          next_r.tmr = '0;
        end
      end
      smbus_seq_pkg::gen_start: begin
        next_r.tmr = r.tmr + 1'b1;
        if (tick) begin
          next_r.mst = 1'b1;
          next_r.txm = 1'b1;
          next_r.si = 1'b1;
          next_r.sta = 1'b0;
          next_r.addr_ph = 1'b1;
          next_r.scl_lo = 1'b1;
          next_r.tmr = '0;
          next_r.st = smbus_seq_pkg::hold;
        end
      end
      smbus_seq_pkg::hold: begin
        next_r.scl_lo = 1'b1;
        if (si_clr) begin
          next_r.dw = 1'b0;
          next_r.tmr = '0;
          if (r.ack_request_flag) begin
            ackv = r.ackw & r.ack;
            next_r.ack = ackv;
            next_r.sda_lo = ackv;
            next_r.st = smbus_seq_pkg::ack_slot;
            next_r.scl_lo = r.mst;
          end else if (r.mst && next_r.stop_request) begin
            next_r.st = smbus_seq_pkg::gen_stop;
            next_r.sda_lo = 1'b1;
          end else begin
            txm_n = r.mst ? r.dw : (r.txm | r.dw);
            next_r.txm = txm_n;
            next_r.st = smbus_seq_pkg::shifting;
            next_r.cnt = '0;
            next_r.sda_lo = txm_n & ~r.dat[7];
            next_r.scl_lo = r.mst;
          end
        end
      end
      smbus_seq_pkg::shifting: begin
        if (rise) begin
          next_r.dat = {r.dat[6:0], sda_s2};
          next_r.cnt = r.cnt + 1'b1;
          if (r.mst && r.txm && !r.sda_lo && !sda_s2) begin
            next_r.mst = 1'b0;
            next_r.txm = 1'b0;
            next_r.arbl = 1'b1;
            next_r.si = 1'b1;
            next_r.sda_lo = 1'b0;
            next_r.scl_lo = 1'b0;
            next_r.st = smbus_seq_pkg::idle;
          end
        end
        if (fall) begin
          if (r.cnt == smbus_seq_pkg::BITS_PER_BYTE) begin
            if (r.addr_ph && !r.mst) begin
              next_r.rw = r.dat[0];
            end
            if (r.txm) begin
              next_r.sda_lo = 1'b0;
              next_r.st = smbus_seq_pkg::ack_slot;
            end else if (r.hwack) begin
              ackv = (r.addr_ph && !r.mst) ? match : r.ack;
              next_r.sda_lo = ackv;
              next_r.st = smbus_seq_pkg::ack_slot;
            end else begin
              next_r.si = 1'b1;
              next_r.ack_request_flag = 1'b1;
              next_r.ackw = 1'b0;
              next_r.scl_lo = 1'b1;
              next_r.sda_lo = 1'b0;
              next_r.st = smbus_seq_pkg::hold;
            end
          end else begin
            next_r.sda_lo = r.txm & ~r.dat[7];
          end
        end
      end
      smbus_seq_pkg::ack_slot: begin
        if (rise && r.txm) begin
          next_r.ack = ~sda_s2;
        end
        if (fall) begin
          next_r.sda_lo = 1'b0;
          next_r.ack_request_flag = 1'b0;
          next_r.addr_ph = 1'b0;
          next_r.cnt = '0;
          if (r.addr_ph && !r.mst) begin
            next_r.txm = r.rw;
            if (!r.sda_lo) begin
              next_r.txm = 1'b0;
              next_r.st = smbus_seq_pkg::idle;
            end else if (r.hwack) begin
              next_r.si = 1'b1;
              next_r.scl_lo = 1'b1;
              next_r.st = smbus_seq_pkg::hold;
            end else begin
              next_r.st = smbus_seq_pkg::shifting;
              next_r.sda_lo = r.rw & ~r.dat[7];
            end
          end else if (!r.mst && r.txm && !r.ack) begin
            next_r.txm = 1'b0;
            next_r.si = 1'b1;
            next_r.st = smbus_seq_pkg::idle;
          end else if (r.txm || r.hwack) begin
            next_r.si = 1'b1;
            next_r.scl_lo = 1'b1;
            next_r.st = smbus_seq_pkg::hold;
          end else begin
            next_r.st = smbus_seq_pkg::shifting;
          end
        end
      end
      smbus_seq_pkg::gen_stop: begin
        next_r.sda_lo = 1'b1;
        if (tick && !r.scl_lo) begin
          next_r.mst = 1'b0;
          next_r.stop_request = 1'b0;
          next_r.txm = 1'b0;
          next_r.sda_lo = 1'b0;
          next_r.scl_lo = 1'b0;
          next_r.st = smbus_seq_pkg::idle;
        end
      end
    endcase
    // Foreign START restarts address reception, or goes idle with slave inhibit set; our own START is skipped.
    if (start_det && !r.mst && r.st != smbus_seq_pkg::gen_start) begin
      next_r.st = r.slave_inhibit ? smbus_seq_pkg::idle : smbus_seq_pkg::shifting;
      next_r.cnt = '0;
      next_r.txm = 1'b0;
      next_r.addr_ph = ~r.slave_inhibit;
      next_r.sda_lo = 1'b0;
      next_r.scl_lo = 1'b0;
    end else if (stop_det && !r.mst) begin
      next_r.st = smbus_seq_pkg::idle;
      next_r.txm = 1'b0;
      next_r.addr_ph = 1'b0;
      next_r.sda_lo = 1'b0;
      next_r.scl_lo = 1'b0;
    end
    if (!r.en) begin
      next_r.st = smbus_seq_pkg::idle;
      next_r.mst = 1'b0;
      next_r.txm = 1'b0;
      next_r.sda_lo = 1'b0;
      next_r.scl_lo = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // The pins are open drain: only the enables ever change.
  assign o_scl_o = 1'b0;
  assign o_sda_o = 1'b0;
  assign o_scl_oe = r.scl_lo;
  assign o_sda_oe = r.sda_lo;
  assign o_rdata = r.rdata;
  assign o_byte_event = r.si;
  assign o_ack_request = r.ack_request_flag;

  logic quiet;
  assign quiet = i_ce && r.en && !start_det && !stop_det;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_hold_stall: assert property (
    r.st == smbus_seq_pkg::hold |-> o_scl_oe && o_byte_event)
    else $error("bus not stalled during byte event");
  chk_ack_drive: assert property (
    quiet && i_wr && i_addr == smbus_seq_pkg::ADDR_ACK && r.ack_request_flag &&
    r.st == smbus_seq_pkg::hold |=> o_sda_oe == $past(i_wdata[0]) && o_scl_oe)
    else $error("ack write did not reach SDA");
  chk_nack_default: assert property (
    quiet && r.st == smbus_seq_pkg::hold && r.ack_request_flag && !r.ackw && si_clr
    |=> r.st == smbus_seq_pkg::ack_slot && !o_sda_oe)
    else $error("missing ack write did not send nack");
  chk_rx_request: assert property (
    quiet && r.st == smbus_seq_pkg::shifting && fall && !r.txm && !r.hwack &&
    r.cnt == smbus_seq_pkg::BITS_PER_BYTE
    |=> o_ack_request && o_byte_event ##1 o_scl_oe)
    else $error("received byte raised no ack request");
  chk_start_master: assert property (
    quiet && r.st == smbus_seq_pkg::gen_start && tick
    |=> r.mst && r.txm && o_byte_event)
    else $error("START did not enter master mode");
  chk_nack_ignore: assert property (
    quiet && r.st == smbus_seq_pkg::ack_slot && fall && r.addr_ph &&
    !r.mst && !r.sda_lo |=> r.st == smbus_seq_pkg::idle && !r.txm)
    else $error("refused address not ignored");
  chk_tx_after_ack: assert property (
    quiet && r.st == smbus_seq_pkg::ack_slot && fall && r.txm && r.mst
    |=> o_byte_event && r.st == smbus_seq_pkg::hold)
    else $error("send event not after ack");
  chk_stop_end: assert property (
    quiet && r.st == smbus_seq_pkg::gen_stop && tick && !r.scl_lo
    |=> !r.mst && !r.stop_request && !o_sda_oe)
    else $error("STOP did not end master mode");
  chk_master_mode: assert property (
    quiet && r.st == smbus_seq_pkg::hold && si_clr && r.mst &&
    !r.ack_request_flag && !next_r.stop_request |=> r.txm == $past(r.dw))
    else $error("master direction not set by data write");
  chk_addr_match: assert property (
    quiet && r.st == smbus_seq_pkg::shifting && fall && r.hwack &&
    r.addr_ph && !r.mst && r.cnt == smbus_seq_pkg::BITS_PER_BYTE
    |=> o_sda_oe == $past(match))
    else $error("address ack does not follow match");

  cov_master_byte: cover property (
    r.st == smbus_seq_pkg::ack_slot && r.mst ##1 r.st == smbus_seq_pkg::hold);
  cov_slave_addr: cover property (
    r.st == smbus_seq_pkg::ack_slot && r.addr_ph && !r.mst && r.sda_lo);
  cov_soft_ack: cover property (
    r.st == smbus_seq_pkg::hold && r.ack_request_flag && si_clr);
  cov_stop: cover property (
    r.st == smbus_seq_pkg::gen_stop ##1 r.st == smbus_seq_pkg::idle);
endmodule

/* smbus_bus_master_model.sv */
// Far-side bus master model that frames bytes on the two-wire link.
`timescale 1ns/100ps
module smbus_bus_master_model (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // The wait is bounded so that a clock held low forever still ends.
  task automatic wait_high();
    int n;
    n = 0;
    while (i_scl !== 1'b1 && n < 4000) begin
      #5;
      n++;
    end
  endtask
  // The clock stands still between frames, as a real master leaves it.
  task automatic start();
    #1;
    o_sda_oe = 1'b1;
    #80;
    o_scl_oe = 1'b1;
    #40;
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    #1;
    o_sda_oe = ~b;
    #40;
    o_scl_oe = 1'b0;
    wait_high();
    #80;
    r = i_sda;
    o_scl_oe = 1'b1;
    #40;
  endtask
  task automatic byte8(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    o_sda_oe = 1'b0;
  endtask
  task automatic ackbit(output logic a);
    bit_xfer(1'b1, a);
  endtask
  task automatic read8(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
  endtask
  // Slave side for a device that masters the bus: the clock is the
  // device's, so every step waits for its edges on the wire.
  task automatic slave_ack(output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_scl);
      got[i] = i_sda;
      @(negedge i_scl);
    end
    #20;
    o_sda_oe = 1'b1;
    @(negedge i_scl);
    #20;
    o_sda_oe = 1'b0;
  endtask
  task automatic slave_send(input logic [7:0] v, output logic a);
    for (int i = 7; i >= 0; i--) begin
      #1;
      o_sda_oe = ~v[i];
      @(negedge i_scl);
      #20;
    end
    o_sda_oe = 1'b0;
    @(posedge i_scl);
    a = i_sda;
    @(negedge i_scl);
    #20;
  endtask
  task automatic stop();
    #1;
    o_sda_oe = 1'b1;
    #40;
    o_scl_oe = 1'b0;
    wait_high();
    #80;
    o_sda_oe = 1'b0;
    #80;
  endtask
endmodule

/* smbus_ack_and_mode_sequencer_test.sv */
// Self-checking bench for the acknowledge and mode sequencer.
`timescale 1ns/100ps
module smbus_ack_and_mode_sequencer_test;
  logic i_clk;
  logic i_rst_n;
  logic i_wr;
  logic i_rd;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic [7:0] d;
  logic scl_o, scl_oe, sda_o, sda_oe, byte_ev, ack_rq;
  logic p_scl_oe, p_sda_oe, scl, sda, a;
  int err_total;
  int n_tests;
  int n;
  logic ce;
  // Both wires have pull-ups, so a released line reads high.
  assign scl = ~((scl_oe & ~scl_o) | p_scl_oe);
  assign sda = ~((sda_oe & ~sda_o) | p_sda_oe);
  smbus_ack_and_mode_sequencer #(.HALF_CYC(8)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_scl(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_byte_event(byte_ev),
    .o_ack_request(ack_rq)
  );
  smbus_bus_master_model u_pm (
    .i_scl(scl), .i_sda(sda), .o_scl_oe(p_scl_oe), .o_sda_oe(p_sda_oe)
  );
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ad, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic settle();
    @(negedge i_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    ce = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    chk({4'h0, scl_oe, sda_oe, byte_ev, ack_rq}, 8'h00);
    rd(smbus_seq_pkg::ADDR_CTRL, d);
    chk(d, 8'h00);
    rd(3'h7, d);
    chk(d, 8'h00);
    $display("test reset done");
    // Own address 0x34 with bit 0 masked off, hardware ack on.
    wr(smbus_seq_pkg::ADDR_SLV, 8'h68);
    wr(smbus_seq_pkg::ADDR_MASK, 8'hfc);
    wr(smbus_seq_pkg::ADDR_ACK, 8'h01);
    // A write made while the clock enable is low must not land.
    ce <= 1'b0;
    wr(smbus_seq_pkg::ADDR_SLV, 8'h00);
    ce <= 1'b1;
    rd(smbus_seq_pkg::ADDR_SLV, d);
    chk(d, 8'h68);
    wr(smbus_seq_pkg::ADDR_CFG, 8'h05);
    u_pm.start();
    u_pm.byte8(8'h6a);
    settle();
    chk(byte_ev, 1'b0);
    u_pm.ackbit(a);
    settle();
    chk(a, 1'b0);
    chk(byte_ev, 1'b1);
    chk(scl_oe, 1'b1);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.byte8(8'h5c);
    u_pm.ackbit(a);
    chk(a, 1'b0);
    rd(smbus_seq_pkg::ADDR_DATA, d);
    chk(d, 8'h5c);
    wr(smbus_seq_pkg::ADDR_ACK, 8'h00);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.byte8(8'h3c);
    u_pm.ackbit(a);
    settle();
    chk(a, 1'b1);
    chk(byte_ev, 1'b1);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.stop();
    $display("test hardware ack done");
    // Slave read: one byte goes out and the master refuses it.
    wr(smbus_seq_pkg::ADDR_ACK, 8'h01);
    u_pm.start();
    u_pm.byte8(8'h69);
    u_pm.ackbit(a);
    settle();
    chk({a, byte_ev}, 2'h1);
    wr(smbus_seq_pkg::ADDR_DATA, 8'h96);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.read8(d);
    chk(d, 8'h96);
    u_pm.ackbit(a);
    settle();
    chk({a, byte_ev, scl_oe}, 3'h6);
    rd(smbus_seq_pkg::ADDR_ACK, d);
    chk(d, 8'h00);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.stop();
    $display("test slave read done");
    // A foreign address, then an inhibited own address, are refused.
    for (int k = 0; k < 2; k++) begin
      wr(smbus_seq_pkg::ADDR_CFG, k ? 8'h07 : 8'h05);
      u_pm.start();
      u_pm.byte8(k ? 8'h68 : 8'h6c);
      u_pm.ackbit(a);
      settle();
      chk(a, 1'b1);
      chk(byte_ev, 1'b0);
      u_pm.byte8(8'h68);
      u_pm.ackbit(a);
      settle();
      chk({a, byte_ev}, 2'h2);
      u_pm.stop();
    end
    $display("test refused address done");
    wr(smbus_seq_pkg::ADDR_CFG, 8'h01);
    u_pm.start();
    u_pm.byte8(8'h10);
    settle();
    chk({byte_ev, ack_rq, scl_oe}, 3'h7);
    wr(smbus_seq_pkg::ADDR_ACK, 8'h01);
    repeat (2) @(posedge i_clk);
    settle();
    chk({sda_oe, scl_oe}, 2'h3);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.ackbit(a);
    settle();
    chk({a, ack_rq}, 2'h0);
    u_pm.byte8(8'ha5);
    settle();
    chk(byte_ev, 1'b1);
    rd(smbus_seq_pkg::ADDR_DATA, d);
    chk(d, 8'ha5);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.ackbit(a);
    chk(a, 1'b1);
    u_pm.stop();
    $display("test software ack done");
    wr(smbus_seq_pkg::ADDR_CFG, 8'h05);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h09);
    n = 0;
    while (byte_ev !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    rd(smbus_seq_pkg::ADDR_CTRL, d);
    chk(d[smbus_seq_pkg::CTL_MST], 1'b1);
    chk(scl_oe, 1'b1);
    wr(smbus_seq_pkg::ADDR_DATA, 8'ha1);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.slave_ack(d);
    chk(d, 8'ha1);
    settle();
    chk(byte_ev, 1'b1);
    rd(smbus_seq_pkg::ADDR_ACK, d);
    chk(d, 8'h01);
    wr(smbus_seq_pkg::ADDR_ACK, 8'h00);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.slave_send(8'h5a, a);
    settle();
    chk({a, byte_ev}, 2'h3);
    rd(smbus_seq_pkg::ADDR_CTRL, d);
    chk(d[smbus_seq_pkg::CTL_TXM], 1'b0);
    rd(smbus_seq_pkg::ADDR_DATA, d);
    chk(d, 8'h5a);
    wr(smbus_seq_pkg::ADDR_DATA, 8'ha0);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h00);
    u_pm.slave_ack(d);
    chk(d, 8'ha0);
    settle();
    chk(byte_ev, 1'b1);
    wr(smbus_seq_pkg::ADDR_CTRL, 8'h10);
    n = 0;
    while ((scl_oe | sda_oe) !== 1'b0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    repeat (4) @(posedge i_clk);
    rd(smbus_seq_pkg::ADDR_CTRL, d);
    chk(d[smbus_seq_pkg::CTL_MST], 1'b0);
    chk(d[smbus_seq_pkg::CTL_STO], 1'b0);
    $display("test master done");
    summarize();
  end
endmodule
